// ==== lftr_ctrl.v ====
// Functional notes
// [RULE_01] mode 00 apply now, 01 store only, 10 apply stored, 11 discard
// [RULE_02] mode field is bits 7:6 of colour command data byte 5
// [RULE_03] per-channel 3-bit fault code: 000,011,010,101,100 as defined
// [RULE_04] open-LED and shorted-LED faults keep LEDs on, no retry
// [RULE_05] cathode-ground short: cathode off and ballast drive low
// [RULE_06] faults need 8 us on-time, except cathode-ground short
// [RULE_07] thermal warning sets sticky warning flag
// [RULE_08] shutdown temperature turns all LEDs off, sets sticky shutdown flag
// [RULE_09] after shutdown resume only once below warning threshold
// [RULE_10] regulation on warning lowers current one step, increments 4-bit level
// [RULE_11] each step interval: step again if warning persists, else hold
// [RULE_12] threshold select bit lowers warning and shutdown thresholds by 20 C
// [RULE_13] writing one to all-LEDs switch clears reduction level
// [RULE_14] retry-capable fault enters retry and sets retry-active bit
// [RULE_15] each interval retry All_leds_switch if fault persists; then stay off
// [RULE_16] full-status read clears retry counter, retry bit and fault flags
// [RULE_17] one shared retry timer, restarted by each further fault
// [RULE_18] 20 turn-on attempts after each full-status read
// [RULE_19] option selects all-LED or failing-channel-only switch-off
// [RULE_20] sleep frame has byte 1 bit 7 zero; one means broadcast
// [RULE_21] sleep: LEDs off, ballast low, low power, registers reset
// [RULE_22] wake: falling bus edge, dominant for wake time, rising edge
// [RULE_23] all-off option set: cathode-ground short turns all LEDs off
// [RULE_24] thermal regulation only when its enable bit is one
// [RULE_25] detection, codes and retries per channel; only timer shared
`timescale 1ns/100ps
`default_nettype none
`include "lftr_regs.vh"
module lftr_ctrl #(
  parameter integer RETRY_CYC = 250000,
  parameter integer STEP_CYC = 25000000,
  parameter integer WAKE_CYC = 1250,
  parameter integer TEMP_W = 8,
  parameter integer COL_W = 8
) (
  input wire mclk, // 25 MHz
  input wire rst_n, // sync, active low
  input wire colorValid, // one-cycle colour command strobe
  input wire [3*COL_W-1:0] colorData, // new colour, three channels
  input wire [7:0] colorByte5, // data byte 5 of colour command
  input wire cmdValid, // one-cycle other-frame strobe
  input wire [7:0] cmdByte1, // data byte 1 of that frame
  input wire allLedsWr, // one-cycle control write
  input wire allLedsSwitch, // written all-LEDs switch value
  input wire fullStatusRead, // one-cycle full status read
  input wire [2:0] faultRsense, // raw comparator, open sense resistor
  input wire [2:0] faultGnd, // raw, cathode shorted to ground
  input wire [2:0] faultOpen, // raw, open LED
  input wire [2:0] faultShort, // raw, shorted LED
  input wire [TEMP_W-1:0] junctionTemp, // junction temperature, deg C
  input wire [TEMP_W-1:0] warnThreshold, // nominal warning threshold
  input wire [TEMP_W-1:0] shutThreshold, // nominal shutdown threshold
  input wire warningThresholdSelect, // otp: lower thresholds
  input wire thermalRegulationEnable, // otp: regulation on
  input wire faultAllOffOption, // otp: act on all LEDs
  input wire linRx, // bus level, 1 recessive
  output reg [3*COL_W-1:0] colorOut_r, // applied colour
  output reg [2:0] ledCathodeOutput_r, // channel current enables
  output reg ballastDrive_r, // 0 pulls ballast to 0 V
  output wire [8:0] ledFaultCode_r, // three 3-bit codes, ch0 low
  output reg thermalWarningFlag_r, // sticky
  output reg thermalShutdownFlag_r, // sticky
  output reg [3:0] thermalReductionLevel_r, // current steps removed
  output reg thermalCurrentStep_r, // pulse per reduction step
  output reg retryActive_r, // retry mode
  output reg sleep_r // low-power request
);
  localparam [1:0] WK_IDLE = 2'h0;
  localparam [1:0] WK_LOW = 2'h1;
  localparam [1:0] WK_DONE = 2'h2;
  reg [3*COL_W-1:0] colorStore_r;
  // first stage of each synchroniser is read only by the second
  reg [2:0] faultMeta_r;
  reg [2:0] faultSync_r;
  reg [2:0] gndMeta_r;
  reg [2:0] gndSync_r;
  reg [2:0] openMeta_r;
  reg [2:0] openSync_r;
  reg [2:0] shortMeta_r;
  reg [2:0] shortSync_r;
  reg linMeta_r;
  reg linSync_r;
  reg linPrev_r; // resets recessive so reset gives no false edge
  reg [1:0] wkState_r;
  reg [31:0] wkCnt_r;
  reg ledsOn_r;
  reg [31:0] retryTmr_r; // one timer shared by all channels
  reg [31:0] stepTmr_r;
  reg tsdHold_r;
  wire [TEMP_W-1:0] twLim;
  wire [TEMP_W-1:0] tsdLim;
  wire overWarn;
  wire overShut;
  wire retryTick;
  wire [2:0] retryFault;
  wire [2:0] anyGnd;
  wire [2:0] retryOff; // channel held off by retry sequencer
  wire [2:0] retryExpired; // channel used up its attempts
  reg [2:0] onNow;
  wire [2:0] newFault;
  // thresholds below 20 C would wrap; they are assumed higher
  assign twLim = warningThresholdSelect ? warnThreshold - `LFTR_THR_SHIFT : warnThreshold; // RULE_12
  assign tsdLim = warningThresholdSelect ? shutThreshold - `LFTR_THR_SHIFT : shutThreshold; // RULE_12
  assign overWarn = junctionTemp > twLim;
  assign overShut = junctionTemp > tsdLim;
  assign retryTick = (retryTmr_r == 32'h1);
  // pins crossing in from analogue comparators and the bus
  always @(posedge mclk) begin
    faultMeta_r <= faultRsense;
    faultSync_r <= faultMeta_r;
    gndMeta_r <= faultGnd;
    gndSync_r <= gndMeta_r;
    openMeta_r <= faultOpen;
    openSync_r <= openMeta_r;
    shortMeta_r <= faultShort;
    shortSync_r <= shortMeta_r;
    linMeta_r <= linRx;
    linSync_r <= linMeta_r;
  end
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gCh
      reg [15:0] onCnt_r;
      // each channel owns its flops, so each has a single process
      reg [2:0] code_r; // latched until a status read
      reg [4:0] tries_r; // turn-on attempts since the last status read
      reg off_r;
      reg expired_r;
      wire qualified;
      wire [2:0] code;
      assign qualified = onCnt_r >= `LFTR_MIN_ON_CYC; // RULE_06
      assign code = gndSync_r[g] ? `LFTR_F_GND : // RULE_03
        !qualified ? `LFTR_F_NONE :
        faultSync_r[g] ? `LFTR_F_RSENSE :
        openSync_r[g] ? `LFTR_F_OPEN :
        shortSync_r[g] ? `LFTR_F_SHORT : `LFTR_F_NONE;
      assign newFault[g] = (code != `LFTR_F_NONE) && (code_r == `LFTR_F_NONE);
      // open/short LED never enter retry
      assign retryFault[g] = (code == `LFTR_F_RSENSE) || (code == `LFTR_F_GND); // RULE_04
      assign anyGnd[g] = code_r == `LFTR_F_GND;
      assign ledFaultCode_r[3*g+2:3*g] = code_r;
      assign retryOff[g] = off_r;
      assign retryExpired[g] = expired_r;
      always @(posedge mclk) begin
        if (!rst_n || sleep_r) begin
          onCnt_r <= 16'h0000;
          code_r <= `LFTR_F_NONE;
          tries_r <= 5'h00;
          off_r <= 1'b0;
          expired_r <= 1'b0;
        end else begin
          if (!ledCathodeOutput_r[g])
            onCnt_r <= 16'h0000;
          else if (!qualified)
            onCnt_r <= onCnt_r + 16'h0001;
          if (newFault[g]) // RULE_25
            code_r <= code; // RULE_03
          else if (fullStatusRead)
            code_r <= `LFTR_F_NONE; // RULE_16
          if (fullStatusRead) begin
            tries_r <= 5'h00; // RULE_16
            off_r <= 1'b0;
            expired_r <= 1'b0;
          end else if (retryFault[g] && ledCathodeOutput_r[g]) begin
            off_r <= 1'b1; // RULE_15
          end else if (retryTick && off_r && !expired_r) begin
            // attempts are counted 0..19, so the twentieth runs before giving up
            if (tries_r == `LFTR_RETRIES) // RULE_18
              expired_r <= 1'b1;
            else begin
              tries_r <= tries_r + 5'h01;
              off_r <= 1'b0; // RULE_15
            end
          end
        end
      end
    end
  endgenerate
  always @* begin
    onNow = ledsOn_r ? ~retryOff : 3'h0;
    if (faultAllOffOption && (|retryOff)) // RULE_19
      onNow = 3'h0;
    if (faultAllOffOption && (|anyGnd)) // RULE_23
      onNow = 3'h0;
    if (tsdHold_r) // RULE_08
      onNow = 3'h0;
  end
  always @(posedge mclk) begin
    if (!rst_n || sleep_r) begin // RULE_21
      colorOut_r <= {3{`LFTR_RST_COLOR}};
      colorStore_r <= {3{`LFTR_RST_COLOR}};
      ledCathodeOutput_r <= 3'h0;
      ballastDrive_r <= 1'b0;
      ledsOn_r <= 1'b1;
      thermalWarningFlag_r <= 1'b0;
      thermalShutdownFlag_r <= 1'b0;
      thermalReductionLevel_r <= `LFTR_RST_LEVEL;
      thermalCurrentStep_r <= 1'b0;
      retryActive_r <= 1'b0;
      retryTmr_r <= 32'h0;
      stepTmr_r <= 32'h0;
      tsdHold_r <= 1'b0;
    end else begin
      if (colorValid) begin
        case (colorByte5[`LFTR_UPD_MSB:`LFTR_UPD_LSB]) // RULE_02
          `LFTR_UPD_NOW: begin // RULE_01
            colorOut_r <= colorData;
            colorStore_r <= colorData;
          end
          `LFTR_UPD_STORE: colorStore_r <= colorData;
          `LFTR_UPD_APPLY: colorOut_r <= colorStore_r;
          default: colorStore_r <= colorStore_r;
        endcase
      end
      ledCathodeOutput_r <= onNow;
      // tsd also drops the anode; gnd short drops it regardless
      ballastDrive_r <= !(|anyGnd) && !tsdHold_r; // RULE_05
      // hardware set wins over a same-cycle read clear
      if (overWarn)
        thermalWarningFlag_r <= 1'b1; // RULE_07
      else if (fullStatusRead)
        thermalWarningFlag_r <= 1'b0;
      if (overShut) begin
        thermalShutdownFlag_r <= 1'b1; // RULE_08
        tsdHold_r <= 1'b1;
      end else begin
        if (fullStatusRead)
          thermalShutdownFlag_r <= 1'b0;
        if (!overWarn)
          tsdHold_r <= 1'b0; // RULE_09
      end
      if (allLedsWr)
        ledsOn_r <= allLedsSwitch;
      thermalCurrentStep_r <= 1'b0;
      if (allLedsWr && allLedsSwitch) begin
        thermalReductionLevel_r <= `LFTR_RST_LEVEL; // RULE_13
        stepTmr_r <= 32'h0;
      end else if (thermalRegulationEnable) begin // RULE_24
        if (stepTmr_r != 32'h0)
          stepTmr_r <= stepTmr_r - 32'h1; // RULE_11
        // a cleared warning leaves the timer at zero, so the level holds until the warning returns
        if ((stepTmr_r == 32'h0 || stepTmr_r == 32'h1) && overWarn) begin
          stepTmr_r <= STEP_CYC; // RULE_10
          thermalCurrentStep_r <= 1'b1;
          if (thermalReductionLevel_r != 4'hF)
            thermalReductionLevel_r <= thermalReductionLevel_r + 4'h1; // RULE_10
        end
      end
      if (|(newFault & retryFault)) begin
        retryActive_r <= 1'b1; // RULE_14
        retryTmr_r <= RETRY_CYC; // RULE_17
      end else begin
        if (fullStatusRead)
          retryActive_r <= 1'b0; // RULE_16
        if (retryTmr_r > 32'h1)
          retryTmr_r <= retryTmr_r - 32'h1;
        else if (retryTick)
          retryTmr_r <= (|(retryOff & ~retryExpired)) ? RETRY_CYC : 32'h0;
        else if (|(retryOff & ~retryExpired))
          retryTmr_r <= RETRY_CYC;
      end
    end
  end
  // sleep request and bus wake-up
  always @(posedge mclk) begin
    if (!rst_n) begin
      sleep_r <= 1'b0;
      wkState_r <= WK_IDLE;
      wkCnt_r <= 32'h0;
      linPrev_r <= 1'b1;
    end else begin
      linPrev_r <= linSync_r;
      if (!sleep_r) begin
        wkState_r <= WK_IDLE;
        if (cmdValid && !cmdByte1[`LFTR_SLEEP_BIT])
          sleep_r <= 1'b1; // RULE_20
      end else begin
        case (wkState_r)
          WK_IDLE: begin
            wkCnt_r <= 32'h0;
            if (linPrev_r && !linSync_r)
              wkState_r <= WK_LOW; // RULE_22
          end
          WK_LOW: begin
            if (linSync_r)
              wkState_r <= WK_IDLE;
            else if (wkCnt_r >= WAKE_CYC - 1)
              wkState_r <= WK_DONE;
            else
              wkCnt_r <= wkCnt_r + 32'h1;
          end
          WK_DONE: begin
            if (linSync_r) begin
              sleep_r <= 1'b0; // RULE_22
              wkState_r <= WK_IDLE;
            end
          end
          default: wkState_r <= WK_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== lftr_ctrl_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module lftr_ctrl_asserts #(
  parameter integer TEMP_W = 8,
  parameter integer COL_W = 8
) (
  input wire mclk, // clock
  input wire rst_n, // reset
  input wire colorValid, // in
  input wire [3*COL_W-1:0] colorData, // in
  input wire [7:0] colorByte5, // in
  input wire cmdValid, // in
  input wire [7:0] cmdByte1, // in
  input wire allLedsWr, // in
  input wire allLedsSwitch, // in
  input wire [TEMP_W-1:0] junctionTemp, // in
  input wire [TEMP_W-1:0] shutThreshold, // in
  input wire [TEMP_W-1:0] warnThreshold, // in
  input wire warningThresholdSelect, // in
  input wire thermalRegulationEnable, // in
  input wire [3*COL_W-1:0] colorOut_r, // out
  input wire [2:0] ledCathodeOutput_r, // out
  input wire ballastDrive_r, // out
  input wire [8:0] ledFaultCode_r, // out
  input wire thermalWarningFlag_r, // out
  input wire [3:0] thermalReductionLevel_r, // out
  input wire thermalCurrentStep_r, // out
  input wire retryActive_r, // out
  input wire sleep_r // out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // frames landing on a sleep cycle reset the colour, so they are left out
  property p_col; colorValid && colorByte5[7:6] == 2'h0 && !cmdValid && !sleep_r |=> colorOut_r == $past(colorData); endproperty
  a_col: assert property (p_col) else $error("colour not applied");
  property p_keep; colorValid && colorByte5[6] && !cmdValid && !sleep_r |=> $stable(colorOut_r); endproperty
  a_keep: assert property (p_keep) else $error("colour changed");
  property p_slp; cmdValid && !cmdByte1[7] |=> sleep_r; endproperty
  a_slp: assert property (p_slp) else $error("no sleep");
  property p_slpoff; sleep_r && $past(sleep_r) |-> ledCathodeOutput_r == 3'h0 && !ballastDrive_r; endproperty
  a_slpoff: assert property (p_slpoff) else $error("outputs on in sleep");
  property p_tsd; junctionTemp > shutThreshold && !warningThresholdSelect |-> ##[1:3] ledCathodeOutput_r == 3'h0; endproperty
  a_tsd: assert property (p_tsd) else $error("leds on when hot");
  property p_tw; junctionTemp > warnThreshold && !warningThresholdSelect && !sleep_r && !cmdValid |=> thermalWarningFlag_r; endproperty
  a_tw: assert property (p_tw) else $error("warning flag missing");
  property p_lvl; thermalReductionLevel_r != $past(thermalReductionLevel_r) |-> thermalReductionLevel_r == $past(thermalReductionLevel_r) + 4'h1 || thermalReductionLevel_r == 4'h0; endproperty
  a_lvl: assert property (p_lvl) else $error("level jumped");
  property p_reg; !thermalRegulationEnable && !$past(thermalRegulationEnable) |-> !thermalCurrentStep_r; endproperty
  a_reg: assert property (p_reg) else $error("step while disabled");
  property p_clr; allLedsWr && allLedsSwitch && !cmdValid |=> thermalReductionLevel_r == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("level not cleared");
  property p_gnd; $rose(ledFaultCode_r[5:3] == 3'h2) |-> retryActive_r ##1 !ledCathodeOutput_r[1] && !ballastDrive_r; endproperty
  a_gnd: assert property (p_gnd) else $error("ground short not acted on");
endmodule
bind lftr_ctrl lftr_ctrl_asserts #(.TEMP_W(TEMP_W), .COL_W(COL_W)) chk (.mclk, .rst_n, .colorValid,
  .colorData, .colorByte5, .cmdValid, .cmdByte1, .allLedsWr, .allLedsSwitch, .junctionTemp,
  .shutThreshold, .warnThreshold, .warningThresholdSelect, .thermalRegulationEnable, .colorOut_r,
  .ledCathodeOutput_r, .ballastDrive_r, .ledFaultCode_r, .thermalWarningFlag_r,
  .thermalReductionLevel_r, .thermalCurrentStep_r, .retryActive_r, .sleep_r);
`default_nettype wire

// ==== lftr_ctrl_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module lftr_ctrl_test;
  localparam integer RC = 20;
  localparam integer SC = 50;
  localparam integer WC = 10;
  logic mclk, rst_n, colorValid, cmdValid, allLedsWr, allLedsSwitch, fullStatusRead, linRx, p;
  logic warningThresholdSelect, thermalRegulationEnable, faultAllOffOption, ballastDrive_r;
  logic thermalWarningFlag_r, thermalShutdownFlag_r, thermalCurrentStep_r, retryActive_r, sleep_r;
  logic [23:0] colorData, colorOut_r, cur, sto, d;
  logic [7:0] colorByte5, cmdByte1, junctionTemp, warnThreshold, shutThreshold;
  logic [2:0] faultRsense, faultGnd, faultOpen, faultShort, ledCathodeOutput_r;
  logic [8:0] ledFaultCode_r;
  logic [3:0] thermalReductionLevel_r;
  logic [1:0] md;
  logic [1:0] modeSeq [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  int n_errors = 0, compares = 0, k;
  lftr_ctrl #(.RETRY_CYC(RC), .STEP_CYC(SC), .WAKE_CYC(WC)) dut (.mclk, .rst_n, .colorValid,
    .colorData, .colorByte5, .cmdValid, .cmdByte1, .allLedsWr, .allLedsSwitch, .fullStatusRead,
    .faultRsense, .faultGnd, .faultOpen, .faultShort, .junctionTemp, .warnThreshold,
    .shutThreshold, .warningThresholdSelect, .thermalRegulationEnable, .faultAllOffOption, .linRx,
    .colorOut_r, .ledCathodeOutput_r, .ballastDrive_r, .ledFaultCode_r, .thermalWarningFlag_r,
    .thermalShutdownFlag_r, .thermalReductionLevel_r, .thermalCurrentStep_r, .retryActive_r,
    .sleep_r);
  lftr_lin_master m (.mclk, .colorValid, .colorData, .colorByte5, .cmdValid, .cmdByte1,
    .allLedsWr, .allLedsSwitch, .fullStatusRead, .linRx);
  always #20 mclk = ~mclk;
  function automatic logic [23:0] expColor(input logic [1:0] mo, input logic [23:0] dt);
    return mo == 2'h0 ? dt : (mo == 2'h2 ? sto : cur);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic clrFaults;
    {faultRsense, faultGnd, faultOpen, faultShort} = 12'h0;
    cyc(3);
    m.read_status;
    cyc(RC + 10);
  endtask
  task automatic stop_test;
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 10000);
    n_errors++;
    stop_test;
  end
  initial begin
    {mclk, rst_n, warningThresholdSelect, thermalRegulationEnable, faultAllOffOption} = 5'h0;
    {faultRsense, faultGnd, faultOpen, faultShort} = 12'h0;
    {junctionTemp, warnThreshold, shutThreshold} = {8'h19, 8'h64, 8'h82};
    k = $urandom(32'h0258);
    cyc(5);
    rst_n = 1'b1;
    cyc(3);
    `CHK({ballastDrive_r, ledCathodeOutput_r, ledFaultCode_r}, 13'h1E00)
    {cur, sto} = 48'h0;
    for (k = 0; k < 8; k++) begin
      d = $urandom;
      md = modeSeq[k % 4];
      m.send_color(d, md);
      cur = expColor(md, d);
      if (md == 2'h1) sto = d;
      `CHK(colorOut_r, cur)
    end
    faultOpen[1] = 1'b1;
    faultShort[2] = 1'b1;
    cyc(250);
    `CHK(ledFaultCode_r[8:3], 6'h25)
    `CHK({retryActive_r, ledCathodeOutput_r}, 4'h7)
    clrFaults;
    `CHK(ledFaultCode_r, 9'h0)
    faultRsense[0] = 1'b1;
    cyc(250);
    `CHK({retryActive_r, ledFaultCode_r[2:0]}, 4'hB)
    clrFaults;
    faultGnd[1] = 1'b1;
    cyc(6);
    `CHK({retryActive_r, ballastDrive_r, ledCathodeOutput_r, ledFaultCode_r[5:3]}, 8'hAA)
    {k, p} = 0;
    repeat (1500) begin
      @(negedge mclk);
      if (ledCathodeOutput_r[1] && !p) k++;
      p = ledCathodeOutput_r[1];
    end
    `CHK(k, 20)
    faultAllOffOption = 1'b1;
    m.read_status;
    cyc(6);
    `CHK(ledCathodeOutput_r, 3'h0)
    clrFaults;
    faultAllOffOption = 1'b0;
    `CHK({ballastDrive_r, ledCathodeOutput_r}, 4'hF)
    junctionTemp = 8'h6E;
    cyc(SC + 10);
    `CHK({thermalWarningFlag_r, thermalReductionLevel_r}, 5'h10)
    junctionTemp = 8'h19;
    thermalRegulationEnable = 1'b1;
    cyc(3);
    junctionTemp = 8'h6E;
    cyc(3);
    junctionTemp = 8'h19;
    cyc(2 * SC);
    `CHK(thermalReductionLevel_r, 4'h1)
    junctionTemp = 8'h6E;
    k = 0;
    while (!thermalCurrentStep_r && k < SC + 5) begin
      @(negedge mclk);
      k++;
    end
    `CHK(thermalCurrentStep_r, 1'b1)
    junctionTemp = 8'h19;
    cyc(2);
    `CHK(thermalReductionLevel_r, 4'h2)
    junctionTemp = 8'h8C;
    cyc(3);
    `CHK({thermalShutdownFlag_r, ledCathodeOutput_r}, 4'h8)
    junctionTemp = 8'h6E;
    cyc(5);
    `CHK(ledCathodeOutput_r, 3'h0)
    junctionTemp = 8'h19;
    cyc(5);
    `CHK(ledCathodeOutput_r, 3'h7)
    m.write_all(1'b1);
    `CHK(thermalReductionLevel_r, 4'h0)
    m.read_status;
    junctionTemp = warnThreshold - 8'h0F;
    cyc(3);
    `CHK(thermalWarningFlag_r, 1'b0)
    warningThresholdSelect = 1'b1;
    cyc(3);
    `CHK(thermalWarningFlag_r, 1'b1)
    {junctionTemp, warningThresholdSelect, thermalRegulationEnable} = 10'h064;
    m.send_cmd(8'h80 | 8'($urandom));
    `CHK(sleep_r, 1'b0)
    m.send_cmd(8'h7F & 8'($urandom));
    cyc(2);
    `CHK({sleep_r, ballastDrive_r, ledCathodeOutput_r, colorOut_r}, {2'h2, 27'h0})
    m.wake(3);
    cyc(6);
    `CHK(sleep_r, 1'b1)
    m.wake(WC + 4);
    cyc(6);
    `CHK(sleep_r, 1'b0)
    stop_test;
  end
endmodule
`default_nettype wire

// ==== lftr_lin_master.sv ====
`timescale 1ns/100ps
`default_nettype none
module lftr_lin_master (
  input wire logic mclk, // clock
  output logic colorValid, // colour strobe
  output logic [23:0] colorData, // colour
  output logic [7:0] colorByte5, // mode byte
  output logic cmdValid, // frame strobe
  output logic [7:0] cmdByte1, // frame byte 1
  output logic allLedsWr, // switch write
  output logic allLedsSwitch, // switch value
  output logic fullStatusRead, // status read
  output logic linRx // bus, 1 recessive
);
  initial begin
    {colorValid, cmdValid, allLedsWr, fullStatusRead} = 4'h0;
    {colorData, colorByte5, cmdByte1, allLedsSwitch, linRx} = 42'h1;
  end
  task automatic send_color(input logic [23:0] d, input logic [1:0] md);
    @(negedge mclk);
    colorData = d;
    colorByte5 = {md, 6'h2A};
    colorValid = 1'b1;
    @(negedge mclk);
    colorValid = 1'b0;
    // released data never repeats the last value
    colorData = ~d;
  endtask
  task automatic send_cmd(input logic [7:0] b);
    @(negedge mclk);
    cmdByte1 = b;
    cmdValid = 1'b1;
    @(negedge mclk);
    cmdValid = 1'b0;
    cmdByte1 = ~b;
  endtask
  task automatic write_all(input logic v);
    @(negedge mclk);
    allLedsSwitch = v;
    allLedsWr = 1'b1;
    @(negedge mclk);
    allLedsWr = 1'b0;
  endtask
  task automatic read_status;
    @(negedge mclk);
    fullStatusRead = 1'b1;
    @(negedge mclk);
    fullStatusRead = 1'b0;
  endtask
  task automatic wake(input int n);
    @(negedge mclk);
    linRx = 1'b0;
    repeat (n) @(negedge mclk);
    linRx = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== lftr_regs.vh ====
`ifndef LFTR_REGS_VH
`define LFTR_REGS_VH
// colour update modes
`define LFTR_UPD_NOW 2'h0
`define LFTR_UPD_STORE 2'h1
`define LFTR_UPD_APPLY 2'h2
`define LFTR_UPD_DISCARD 2'h3
// position of the mode field in colour byte 5 and of the sleep bit in byte 1
`define LFTR_UPD_MSB 7
`define LFTR_UPD_LSB 6
`define LFTR_SLEEP_BIT 7
// per-channel fault codes
`define LFTR_F_NONE 3'h0
`define LFTR_F_RSENSE 3'h3
`define LFTR_F_GND 3'h2
`define LFTR_F_OPEN 3'h5
`define LFTR_F_SHORT 3'h4
// reset values
`define LFTR_RST_LEVEL 4'h0
`define LFTR_RST_COLOR 8'h00
// timing
`define LFTR_CLK_MHZ 25
`define LFTR_MIN_ON_NS 8000
`define LFTR_MIN_ON_CYC ((`LFTR_MIN_ON_NS * `LFTR_CLK_MHZ + 999) / 1000)
`define LFTR_RETRIES 5'h14
`define LFTR_THR_SHIFT 8'h14
`endif
